// [sra_rx_status.sv]
/*
 * sra_rx_status: lock supervision, mute control, sticky lock_lost_sticky flag, compression code
 * capture, interrupt status/mask, AXI4-Lite register slave and auxiliary TDM frame routing.
 * Assumes the receiver front end delivers decoded samples on clk with a one-cycle sampleValid,
 * while the lock level and the serial clocks arrive asynchronously and are synchronised here.
 */
// Summary of operation
// - compression code readable, reset zero
// - lock loss mutes audio output
// - resume bit zero: stay muted until toggled
// - resume bit one: unmute on relock
// - sticky flag sets when lock lost
// - writing resume one clears sticky flag
// - enabled port emits eight-slot TDM stream
// - slot 0: left audio, eight zeros
// - slot 1: left P V U C bits
// - slot 2: codec and audio type bits
// - slots 3 and 6 all zero
// - slot 4: right audio, eight zeros
// - slot 5: right P V U C bits
// - slot 7: block start bit
// - one-hot select routes to port 0-3
// - clock source: recovered or generator clocks
module sra_rx_status (
   input wire logic clk,
   input wire logic resetn,
   // AXI4-Lite slave
   input wire logic [sra_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sra_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // receiver front end
   input wire logic rxLockIn,
   input wire logic sampleValid,
   input wire logic [sra_pkg::AUDIO_BITS-1:0] leftAudio,
   input wire logic [sra_pkg::AUDIO_BITS-1:0] rightAudio,
   input wire logic [3:0] leftFlags,
   input wire logic [3:0] rightFlags,
   input wire logic codecKindBit,
   input wire logic audioTypeBit,
   input wire logic blockStart,
   input wire logic [15:0] compressionCode,
   // serial clocks from recovery and from the internal generator
   input wire logic recBitClkIn,
   input wire logic recFrameClkIn,
   input wire logic genBitClkIn,
   input wire logic genFrameClkIn,
   // outputs
   output logic rxAudioMuted,
   output logic [sra_pkg::PORT_CNT-1:0] serialOutPort,
   output logic auxBitClkOut,
   output logic auxFrameClkOut,
   output logic irq
);
   typedef struct packed {
      logic awHave;
      logic [sra_pkg::IDX_W-1:0] awIdx;
      logic awBad;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awReady;
      logic wReady;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [15:0] compCode;
      logic autoResume;
      logic [sra_pkg::AUX_EN_W-1:0] auxEn;
      logic lockLostSticky;
      logic [sra_pkg::IRQ_W-1:0] irqStatus;
      logic [sra_pkg::IRQ_W-1:0] irqMask;
      logic irqOut;
      logic prevLock;
      logic prevResume;
      logic mutedHold;
      logic muteOut;
      logic prevBit;
      logic prevFrame;
      logic bitOut;
      logic frameOut;
      logic [sra_pkg::PORT_CNT-1:0] ports;
      logic [sra_pkg::AUDIO_BITS-1:0] sLeft;
      logic [sra_pkg::AUDIO_BITS-1:0] sRight;
      logic [3:0] sLFlags;
      logic [3:0] sRFlags;
      logic sCodec;
      logic sAudioType;
      logic sBlock;
   } sra_main_state_t;

   localparam sra_main_state_t ST_RESET = '{
      awReady: 1'b1,
      wReady: 1'b1,
      arReady: 1'b1,
      compCode: sra_pkg::COMPR_RESET,
      auxEn: sra_pkg::AUX_EN_RESET,
      irqStatus: sra_pkg::IRQ_RESET,
      irqMask: sra_pkg::IRQ_RESET,
      default: '0
   };

   sra_main_state_t st_reg;
   sra_main_state_t st_next;

   logic [sra_pkg::SYN_W-1:0] syncIn;
   logic [sra_pkg::SYN_W-1:0] syncLvl;
   logic [sra_pkg::PORT_CNT-1:0] portNext;

   sra_tdm_if tdm ();

   assign syncIn = {genFrameClkIn, genBitClkIn, recFrameClkIn, recBitClkIn, rxLockIn};

   sra_sync_bank #(
      .W(sra_pkg::SYN_W)
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .asyncIn(syncIn),
      .syncOut(syncLvl)
   );

   sra_tdm_shifter u_shift (
      .clk(clk),
      .resetn(resetn),
      .tdm(tdm.fmt)
   );

   // only an exact one-hot code selects a port; any other value routes nowhere
   genvar gi;
   generate
      for (gi = 0; gi < sra_pkg::PORT_CNT; gi++) begin : g_port
         assign portNext[gi] = (st_reg.auxEn[sra_pkg::AUX_SEL_W-1:0] == 4'(1 << gi)) && tdm.serialBit;
      end
   endgenerate

   function automatic logic [31:0] read_reg(input sra_main_state_t s, input logic [sra_pkg::IDX_W-1:0] idx);
      logic [31:0] v;
      v = 32'h00000000;
      case (idx)
         sra_pkg::IDX_COMPR_CODE: v[15:0] = s.compCode;
         sra_pkg::IDX_AUTO_RESUME: v[sra_pkg::RESUME_BIT] = s.autoResume;
         sra_pkg::IDX_LOCK_LOST: v[sra_pkg::LOST_BIT] = s.lockLostSticky;
         sra_pkg::IDX_AUX_ENABLE: v[sra_pkg::AUX_EN_W-1:0] = s.auxEn;
         sra_pkg::IDX_IRQ_STATUS: v[sra_pkg::IRQ_W-1:0] = s.irqStatus;
         sra_pkg::IDX_IRQ_MASK: v[sra_pkg::IRQ_W-1:0] = s.irqMask;
         sra_pkg::IDX_LIVE_STATUS: begin
            v[sra_pkg::LIVE_LOCK] = s.prevLock;
            v[sra_pkg::LIVE_MUTE] = s.muteOut;
         end
         default: v = 32'h00000000;
      endcase
      return v;
   endfunction

   function automatic logic idx_mapped(input logic [sra_pkg::IDX_W-1:0] idx);
      return (idx == sra_pkg::IDX_COMPR_CODE) || (idx == sra_pkg::IDX_AUTO_RESUME) ||
             (idx == sra_pkg::IDX_LOCK_LOST) || (idx == sra_pkg::IDX_AUX_ENABLE) ||
             (idx == sra_pkg::IDX_IRQ_STATUS) || (idx == sra_pkg::IDX_IRQ_MASK) ||
             (idx == sra_pkg::IDX_LIVE_STATUS);
   endfunction

   always_comb begin
      logic lockNow;
      logic lockFell;
      logic lockRose;
      logic resumeFell;
      logic clearSticky;
      logic bitClk;
      logic frameClk;
      logic bitFall;
      logic frameRise;
      logic doWrite;
      logic [sra_pkg::IRQ_W-1:0] irqSet;
      logic [sra_pkg::IRQ_W-1:0] irqClr;
      logic [sra_pkg::AUDIO_BITS-1:0] audL;
      logic [sra_pkg::AUDIO_BITS-1:0] audR;
      lockNow = syncLvl[sra_pkg::SYN_LOCK];
      lockFell = st_reg.prevLock && !lockNow;
      lockRose = !st_reg.prevLock && lockNow;
      resumeFell = st_reg.prevResume && !st_reg.autoResume;
      clearSticky = 1'b0;
      irqSet = '0;
      irqClr = '0;
      doWrite = 1'b0;
      bitClk = 1'b0;
      frameClk = 1'b0;
      bitFall = 1'b0;
      frameRise = 1'b0;
      audL = '0;
      audR = '0;
      st_next = st_reg;

      // write address and data are taken independently, in either order
      if (s_axi_awvalid && st_reg.awReady) begin
         st_next.awHave = 1'b1;
         st_next.awIdx = s_axi_awaddr[sra_pkg::ADDR_W-1:2];
      end
      if (s_axi_wvalid && st_reg.wReady) begin
         st_next.wHave = 1'b1;
         st_next.wData = s_axi_wdata;
         st_next.wStrb = s_axi_wstrb;
      end
      if (st_reg.bValid && s_axi_bready) begin
         st_next.bValid = 1'b0;
      end
      if (st_reg.awHave && st_reg.wHave && !st_reg.bValid) begin
         doWrite = 1'b1;
         st_next.awHave = 1'b0;
         st_next.wHave = 1'b0;
         st_next.bValid = 1'b1;
         st_next.bResp = idx_mapped(st_reg.awIdx) ? sra_pkg::RESP_OKAY : sra_pkg::RESP_SLVERR;
      end
      if (doWrite && st_reg.wStrb[0]) begin
         case (st_reg.awIdx)
            sra_pkg::IDX_AUTO_RESUME: begin
               st_next.autoResume = st_reg.wData[sra_pkg::RESUME_BIT];
               clearSticky = st_reg.wData[sra_pkg::RESUME_BIT];
            end
            sra_pkg::IDX_AUX_ENABLE: st_next.auxEn = st_reg.wData[sra_pkg::AUX_EN_W-1:0];
            sra_pkg::IDX_IRQ_STATUS: irqClr = st_reg.wData[sra_pkg::IRQ_W-1:0];
            sra_pkg::IDX_IRQ_MASK: st_next.irqMask = st_reg.wData[sra_pkg::IRQ_W-1:0];
            default: clearSticky = 1'b0;
         endcase
      end
      // one write in flight: channels reopen only after the response is accepted
      st_next.awReady = !st_next.awHave && !st_next.bValid;
      st_next.wReady = !st_next.wHave && !st_next.bValid;

      // read channel
      if (s_axi_arvalid && st_reg.arReady) begin
         st_next.rValid = 1'b1;
         st_next.rData = read_reg(st_reg, s_axi_araddr[sra_pkg::ADDR_W-1:2]);
         st_next.rResp = idx_mapped(s_axi_araddr[sra_pkg::ADDR_W-1:2]) ? sra_pkg::RESP_OKAY : sra_pkg::RESP_SLVERR;
      end else if (st_reg.rValid && s_axi_rready) begin
         st_next.rValid = 1'b0;
      end
      st_next.arReady = !st_next.rValid;

      // lock supervision and mute
      st_next.prevLock = lockNow;
      st_next.prevResume = st_reg.autoResume;
      if (lockFell) begin
         st_next.mutedHold = 1'b1;
      end else if (st_reg.autoResume && lockNow) begin
         st_next.mutedHold = 1'b0;
      end else if (resumeFell) begin
         st_next.mutedHold = 1'b0;
      end
      // not yet locked also keeps audio muted
      st_next.muteOut = st_next.mutedHold || !lockNow;

      // a loss in the same cycle as the clearing write keeps the flag set
      if (lockFell) begin
         st_next.lockLostSticky = 1'b1;
      end else if (clearSticky) begin
         st_next.lockLostSticky = 1'b0;
      end

      // sample capture; the code only updates while compressed audio is flagged
      if (sampleValid) begin
         st_next.sLeft = leftAudio;
         st_next.sRight = rightAudio;
         st_next.sLFlags = leftFlags;
         st_next.sRFlags = rightFlags;
         st_next.sCodec = codecKindBit;
         st_next.sAudioType = audioTypeBit;
         st_next.sBlock = blockStart;
         if (audioTypeBit) begin
            st_next.compCode = compressionCode;
         end
      end

      // interrupts: set wins over write-one-to-clear
      irqSet[sra_pkg::IRQ_LOST] = lockFell;
      irqSet[sra_pkg::IRQ_RELOCK] = lockRose;
      irqSet[sra_pkg::IRQ_CODE] = st_next.compCode != st_reg.compCode;
      st_next.irqStatus = (st_reg.irqStatus & ~irqClr) | irqSet;
      st_next.irqOut = |(st_next.irqStatus & st_next.irqMask);

      // serial clock selection and edge detection on the system clock
      bitClk = st_reg.auxEn[sra_pkg::AUX_CLK_BIT] ? syncLvl[sra_pkg::SYN_GEN_BIT] : syncLvl[sra_pkg::SYN_REC_BIT];
      frameClk = st_reg.auxEn[sra_pkg::AUX_CLK_BIT] ? syncLvl[sra_pkg::SYN_GEN_FRAME] : syncLvl[sra_pkg::SYN_REC_FRAME];
      st_next.prevBit = bitClk;
      st_next.prevFrame = frameClk;
      bitFall = st_reg.prevBit && !bitClk;
      frameRise = !st_reg.prevFrame && frameClk;
      st_next.bitOut = bitClk;
      st_next.frameOut = frameClk;
      tdm.loadFrame = frameRise;
      tdm.shiftBit = bitFall && !frameRise;

      // muted audio goes out as zeros; side-channel bits still pass
      audL = st_reg.muteOut ? '0 : st_reg.sLeft;
      audR = st_reg.muteOut ? '0 : st_reg.sRight;
      tdm.frameWord = {
         audL, 8'h00,
         20'h00000, st_reg.sLFlags, 8'h00,
         22'h000000, st_reg.sCodec, st_reg.sAudioType, 8'h00,
         32'h00000000,
         audR, 8'h00,
         20'h00000, st_reg.sRFlags, 8'h00,
         32'h00000000,
         23'h000000, st_reg.sBlock, 8'h00
      };
      st_next.ports = portNext;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign s_axi_awready = st_reg.awReady;
   assign s_axi_wready = st_reg.wReady;
   assign s_axi_bvalid = st_reg.bValid;
   assign s_axi_bresp = st_reg.bResp;
   assign s_axi_arready = st_reg.arReady;
   assign s_axi_rvalid = st_reg.rValid;
   assign s_axi_rdata = st_reg.rData;
   assign s_axi_rresp = st_reg.rResp;
   assign rxAudioMuted = st_reg.muteOut;
   assign serialOutPort = st_reg.ports;
   assign auxBitClkOut = st_reg.bitOut;
   assign auxFrameClkOut = st_reg.frameOut;
   assign irq = st_reg.irqOut;
endmodule

// [sra_pkg.sv]
/*
 * sra_pkg: shared constants for the receiver status and auxiliary TDM formatter block.
 * Assumes a 32-bit AXI4-Lite register bus in which a register index maps to byte address index*4.
 */
package sra_pkg;
   // register indices; byte address is index*4
   localparam int ADDR_W = 18;
   localparam int IDX_W = 16;
   localparam logic [IDX_W-1:0] IDX_COMPR_CODE = 16'hF603;
   localparam logic [IDX_W-1:0] IDX_AUTO_RESUME = 16'hF604;
   localparam logic [IDX_W-1:0] IDX_LOCK_LOST = 16'hF605;
   localparam logic [IDX_W-1:0] IDX_AUX_ENABLE = 16'hF608;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 16'hF610;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'hF611;
   localparam logic [IDX_W-1:0] IDX_LIVE_STATUS = 16'hF612;

   // field positions
   localparam int RESUME_BIT = 0;
   localparam int LOST_BIT = 0;
   localparam int AUX_SEL_W = 4;
   localparam int AUX_CLK_BIT = 4;
   localparam int AUX_EN_W = 5;
   localparam int IRQ_W = 3;
   localparam int IRQ_LOST = 0;
   localparam int IRQ_RELOCK = 1;
   localparam int IRQ_CODE = 2;
   localparam int LIVE_LOCK = 0;
   localparam int LIVE_MUTE = 1;

   // reset values
   localparam logic [15:0] COMPR_RESET = 16'h0000;
   localparam logic [AUX_EN_W-1:0] AUX_EN_RESET = 5'h00;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

   // tdm frame layout
   localparam int SLOT_BITS = 32;
   localparam int SLOTS = 8;
   localparam int FRAME_BITS = SLOT_BITS * SLOTS;
   localparam int AUDIO_BITS = 24;
   localparam int PORT_CNT = 4;

   // synchroniser lanes
   localparam int SYN_W = 5;
   localparam int SYN_LOCK = 0;
   localparam int SYN_REC_BIT = 1;
   localparam int SYN_REC_FRAME = 2;
   localparam int SYN_GEN_BIT = 3;
   localparam int SYN_GEN_FRAME = 4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [sra_tdm_if.sv]
/*
 * sra_tdm_if: carries a formatted frame and its load/shift strobes to the shifter.
 * Assumes both ends run on the same system clock.
 */
interface sra_tdm_if;
   logic loadFrame;
   logic shiftBit;
   logic [sra_pkg::FRAME_BITS-1:0] frameWord;
   logic serialBit;
   modport ctrl (output loadFrame, output shiftBit, output frameWord, input serialBit);
   modport fmt (input loadFrame, input shiftBit, input frameWord, output serialBit);
endinterface

// [sra_sync_bank.sv]
/*
 * sra_sync_bank: two-flop synchronisers for levels arriving from outside the clock domain.
 * Assumes each lane is an independent level; no multi-bit coherence is offered.
 */
module sra_sync_bank #(
   parameter int W = 5
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } sra_sync_state_t;

   sra_sync_state_t st_reg;
   sra_sync_state_t st_next;

   always_comb begin
      st_next.stage1 = asyncIn;
      st_next.stage2 = st_reg.stage1;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign syncOut = st_reg.stage2;
endmodule

// [sra_tdm_shifter.sv]
/*
 * sra_tdm_shifter: holds one TDM frame and shifts it out MSB first.
 * Assumes load and shift strobes are single-cycle pulses; load wins over shift.
 */
module sra_tdm_shifter (
   input wire logic clk,
   input wire logic resetn,
   sra_tdm_if.fmt tdm
);
   typedef struct packed {
      logic [sra_pkg::FRAME_BITS-1:0] shift;
   } sra_shift_state_t;

   sra_shift_state_t st_reg;
   sra_shift_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (tdm.loadFrame) begin
         st_next.shift = tdm.frameWord;
      end else if (tdm.shiftBit) begin
         st_next.shift = {st_reg.shift[sra_pkg::FRAME_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tdm.serialBit = st_reg.shift[sra_pkg::FRAME_BITS-1];
endmodule

// [sra_rx_status_sva.sv]
/*
 * sra_rx_status_sva: port-level checks for sra_rx_status.
 * Assumes one clock domain, clk, with resetn asynchronous and active low.
 */
module sra_rx_status_sva (
   input wire logic clk,
   input wire logic resetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic rxLockIn,
   input wire logic recBitClkIn,
   input wire logic recFrameClkIn,
   input wire logic genFrameClkIn,
   input wire logic genBitClkIn,
   input wire logic rxAudioMuted,
   input wire logic [sra_pkg::PORT_CNT-1:0] serialOutPort,
   input wire logic auxBitClkOut,
   input wire logic auxFrameClkOut
);
   logic [2:0] upReg;
   // clock pipeline holds reset values for a few edges after release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) upReg <= 3'h0;
      else if (upReg != 3'h7) upReg <= upReg + 3'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence wrBoth;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence lockGone;
      !rxLockIn [*4];
   endsequence
   mute_on_loss_a: assert property (lockGone |=> rxAudioMuted)
      else $error("audio not muted after lock loss");
   unmute_needs_lock_a: assert property ($fell(rxAudioMuted) |->
      $past(rxLockIn, 2) || $past(rxLockIn, 3) || $past(rxLockIn, 4))
      else $error("audio unmuted without lock");
   port_onehot_a: assert property ($onehot0(serialOutPort))
      else $error("more than one serial port active");
   aux_clk_follow_a: assert property (upReg == 3'h7 |->
      auxBitClkOut == $past(recBitClkIn, 3) || auxBitClkOut == $past(genBitClkIn, 3))
      else $error("aux bit clock not from a source clock");
   aux_frame_follow_a: assert property (upReg == 3'h7 |->
      auxFrameClkOut == $past(recFrameClkIn, 3) || auxFrameClkOut == $past(genFrameClkIn, 3))
      else $error("aux frame clock not from a source clock");
   wr_answer_a: assert property (wrBoth |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted during response");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted during data phase");
   rd_err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == sra_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("error read returned data");
endmodule

bind sra_rx_status sra_rx_status_sva sra_rx_status_sva_inst (.*);

// [sra_src_model.sv]
/*
 * sra_src_model: serial clock source for the aux port and capture of one TDM frame per request.
 * Assumes the bench holds runFrame until frameCnt moves; clocks stand still low between frames.
 */
module sra_src_model (
   input wire logic runFrame,
   input wire logic useGen,
   input wire logic sdata,
   output logic recBitClkIn,
   output logic recFrameClkIn,
   output logic genBitClkIn,
   output logic genFrameClkIn,
   output logic [255:0] gotFrame,
   output logic [7:0] frameCnt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic bck = 1'b0;
   logic fck = 1'b0;
   // idle source stands still, so a wrong clock-source choice yields no frame
   assign recBitClkIn = bck & ~useGen;
   assign recFrameClkIn = fck & ~useGen;
   assign genBitClkIn = bck & useGen;
   assign genFrameClkIn = fck & useGen;
   initial begin
      gotFrame = '0;
      frameCnt = 8'h00;
      forever begin
         wait (runFrame);
         // off the clk grid, so no pin moves in the time step of a clk edge
         #0.1;
         for (int i = 0; i < 257; i++) begin
            bck = 1'b1;
            if (i > 0) gotFrame = {gotFrame[254:0], sdata};
            #62.5;
            if (i < 256) begin
               bck = 1'b0;
               fck = (i < 128);
            end
            #62.5;
         end
         bck = 1'b0;
         frameCnt++;
         wait (!runFrame);
      end
   end
endmodule

// [tb.sv]
/*
 * tb: drives sra_rx_status over AXI4-Lite and its receiver inputs; checks registers,
 * mute and lock handling, interrupts and the aux TDM frame. Assumes sra_src_model as far side.
 */
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, resetn = 1'b0;
   logic [sra_pkg::ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic rxLockIn = 1'b0, sampleValid = 1'b0, codecKindBit = 1'b0, audioTypeBit = 1'b0, blockStart = 1'b0;
   logic [23:0] leftAudio = '0, rightAudio = '0;
   logic [3:0] leftFlags = '0, rightFlags = '0, serialOutPort;
   logic [15:0] compressionCode = '0, code;
   logic recBitClkIn, recFrameClkIn, genBitClkIn, genFrameClkIn, rxAudioMuted, auxBitClkOut, auxFrameClkOut, irq;
   logic runFrame = 1'b0, useGen = 1'b0;
   logic [1:0] portIdx = 2'h0;
   logic [7:0] frameCnt;
   logic [255:0] gotFrame;
   logic [3:0] selTab [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h5};
   int err_total = 0, num_checks = 0, cyc = 0, busyPorts;

   always #4 clk = ~clk;
   sra_rx_status sra_rx_status_inst (.*);
   sra_src_model sra_src_model_inst (.runFrame, .useGen, .sdata(serialOutPort[portIdx]), .recBitClkIn,
      .recFrameClkIn, .genBitClkIn, .genFrameClkIn, .gotFrame, .frameCnt);

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chkf(input logic [255:0] e, input logic [255:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR tdm frame expected %h seen %h", e, g);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      repeat (4) @(posedge clk);
   endtask
   task automatic rdc(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er, input string what);
      @(posedge clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
      chk(what, e, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask
   task automatic lock(input logic v);
      @(posedge clk);
      rxLockIn <= v;
      repeat (8) @(posedge clk);
   endtask
   task automatic push(input logic at);
      logic [63:0] rnd;
      rnd = {$urandom(), $urandom()};
      @(posedge clk);
      {leftAudio, rightAudio, leftFlags, rightFlags} <= rnd[55:0];
      {codecKindBit, blockStart, compressionCode} <= rnd[63:46];
      audioTypeBit <= at;
      sampleValid <= 1'b1;
      @(posedge clk);
      sampleValid <= 1'b0;
   endtask
   task automatic do_frame();
      logic [7:0] c;
      c = frameCnt;
      busyPorts = 0;
      runFrame <= 1'b1;
      for (int n = 0; n < 6000 && frameCnt == c; n++) begin
         @(posedge clk);
         if (serialOutPort !== 4'h0) busyPorts++;
      end
      chk("frame done", 32'h1, {31'h0, frameCnt != c});
      runFrame <= 1'b0;
   endtask
   function automatic logic [255:0] exp_frame();
      exp_frame = {leftAudio, 8'h00, 20'h00000, leftFlags, 8'h00, 22'h000000, codecKindBit, audioTypeBit, 8'h00,
         32'h00000000, rightAudio, 8'h00, 20'h00000, rightFlags, 8'h00, 32'h00000000, 23'h000000, blockStart, 8'h00};
   endfunction
   task automatic done(input string t);
      $display("test %s finished", t);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         complete_run();
      end
   end

   initial begin
      void'($urandom(32'h3CD9));
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      rdc(sra_pkg::IDX_COMPR_CODE, 32'h0, sra_pkg::RESP_OKAY, "compression code");
      rdc(sra_pkg::IDX_AUTO_RESUME, 32'h0, sra_pkg::RESP_OKAY, "auto resume");
      rdc(sra_pkg::IDX_LOCK_LOST, 32'h0, sra_pkg::RESP_OKAY, "lock lost");
      rdc(sra_pkg::IDX_AUX_ENABLE, 32'h0, sra_pkg::RESP_OKAY, "aux enable");
      rdc(16'h0F00, 32'h0, sra_pkg::RESP_SLVERR, "unmapped");
      wr(16'h0F00, 32'h1, sra_pkg::RESP_SLVERR);
      wr(sra_pkg::IDX_COMPR_CODE, 32'hFFFF, sra_pkg::RESP_OKAY);
      rdc(sra_pkg::IDX_COMPR_CODE, 32'h0, sra_pkg::RESP_OKAY, "read-only code");
      done("registers");
      wr(sra_pkg::IDX_IRQ_MASK, 32'h1, sra_pkg::RESP_OKAY);
      lock(1'b1);
      chk("muted", 32'h0, {31'h0, rxAudioMuted});
      lock(1'b0);
      chk("muted", 32'h1, {31'h0, rxAudioMuted});
      chk("irq", 32'h1, {31'h0, irq});
      lock(1'b1);
      chk("muted", 32'h1, {31'h0, rxAudioMuted});
      rdc(sra_pkg::IDX_LOCK_LOST, 32'h1, sra_pkg::RESP_OKAY, "lock lost");
      lock(1'b0);
      wr(sra_pkg::IDX_AUTO_RESUME, 32'h1, sra_pkg::RESP_OKAY);
      rdc(sra_pkg::IDX_LOCK_LOST, 32'h0, sra_pkg::RESP_OKAY, "lock lost");
      wr(sra_pkg::IDX_AUTO_RESUME, 32'h0, sra_pkg::RESP_OKAY);
      lock(1'b1);
      chk("muted", 32'h0, {31'h0, rxAudioMuted});
      rdc(sra_pkg::IDX_LOCK_LOST, 32'h0, sra_pkg::RESP_OKAY, "lock lost");
      rdc(sra_pkg::IDX_IRQ_STATUS, 32'h3, sra_pkg::RESP_OKAY, "irq status");
      wr(sra_pkg::IDX_IRQ_STATUS, 32'h7, sra_pkg::RESP_OKAY);
      chk("irq", 32'h0, {31'h0, irq});
      done("manual resume");
      wr(sra_pkg::IDX_IRQ_MASK, 32'h0, sra_pkg::RESP_OKAY);
      wr(sra_pkg::IDX_AUTO_RESUME, 32'h1, sra_pkg::RESP_OKAY);
      lock(1'b0);
      chk("muted", 32'h1, {31'h0, rxAudioMuted});
      chk("irq", 32'h0, {31'h0, irq});
      lock(1'b1);
      chk("muted", 32'h0, {31'h0, rxAudioMuted});
      rdc(sra_pkg::IDX_LIVE_STATUS, 32'h1, sra_pkg::RESP_OKAY, "live status");
      rdc(sra_pkg::IDX_LOCK_LOST, 32'h1, sra_pkg::RESP_OKAY, "lock lost");
      wr(sra_pkg::IDX_IRQ_MASK, 32'h1, sra_pkg::RESP_OKAY);
      chk("irq", 32'h1, {31'h0, irq});
      done("auto resume");
      push(1'b1);
      code = compressionCode;
      rdc(sra_pkg::IDX_COMPR_CODE, {16'h0000, code}, sra_pkg::RESP_OKAY, "compression code");
      push(1'b0);
      rdc(sra_pkg::IDX_COMPR_CODE, {16'h0000, code}, sra_pkg::RESP_OKAY, "held code");
      rdc(sra_pkg::IDX_IRQ_STATUS, 32'h7, sra_pkg::RESP_OKAY, "irq status");
      done("compression code");
      for (int i = 0; i < 6; i++) begin
         portIdx <= i[1:0];
         useGen <= i[0];
         wr(sra_pkg::IDX_AUX_ENABLE, {27'h0000000, i[0], selTab[i]}, sra_pkg::RESP_OKAY);
         push(1'($urandom()));
         do_frame();
         if (i < 4) chkf(exp_frame(), gotFrame);
         else chk("busy ports", 32'h0, busyPorts);
         done("tdm frame");
      end
      complete_run();
   end
endmodule
